// ===== pkg/ccr_pkg.sv
// constants, types and helpers of the calendar clock register block
//=====================================================================
// Summary of operation
// R1 - writing one restarts the sub-second counter
// R2 - time fields at 2015..201b; writes set time
// R3 - time write needs preceding write-enable location write
// R4 - seconds and minutes count 00 to 59
// R5 - hours count 00 to 23, 00 midnight
// R6 - weekday cycles 01 to 07, 01 Sunday
// R7 - date 01 to 31, month 01 to 12
// R8 - year 00 to 99, multiples of four leap
// R9 - chip reset leaves time fields unchanged
// R10 - calendar kept across operating and battery modes
// R11 - two-bit fine trim, read/write, resets zero
// R12 - seven-bit analog trim, read/write, resets 40
// R13 - software keeps coarse trim within allowed range
// R14 - coarse and fine trims separate, one number
// R15 - each second advances with carries, month lengths
// R16 - one enabling write authorises one time write
package ccr_pkg;

    //=================================================================
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    //=================================================================
    // register offsets
    localparam logic [15:0] OFS_RESTART = 16'h2010;
    localparam logic [15:0] OFS_ANALOG = 16'h2011;
    localparam logic [15:0] OFS_SEC = 16'h2015;
    localparam logic [15:0] OFS_MIN = 16'h2016;
    localparam logic [15:0] OFS_HOUR = 16'h2017;
    localparam logic [15:0] OFS_WDAY = 16'h2018;
    localparam logic [15:0] OFS_DATE = 16'h2019;
    localparam logic [15:0] OFS_MONTH = 16'h201a;
    localparam logic [15:0] OFS_YEAR = 16'h201b;
    localparam logic [15:0] OFS_COARSE_HI = 16'h201c;
    localparam logic [15:0] OFS_COARSE_MID = 16'h201d;
    localparam logic [15:0] OFS_TRIM_LO = 16'h201e;
    localparam logic [15:0] OFS_WRITE_EN = 16'h201f;

    //=================================================================
    // field positions
    localparam int RESTART_BIT = 0;
    localparam int FINE_MSB = 1;
    localparam int COARSE_LO_LSB = 2;

    //=================================================================
    // reset values
    localparam logic [6:0] ANALOG_RST = 7'h40;
    localparam logic [1:0] FINE_RST = 2'h0;
    localparam logic [16:0] COARSE_RST = 17'h10000;
    localparam logic RESTART_RST = 1'h0;

    // allowed coarse trim range, kept by software
    localparam logic [16:0] COARSE_MIN = 17'h0ffbf;
    localparam logic [16:0] COARSE_MAX = 17'h10040;

    //=================================================================
    // calendar limits
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WDAY_MIN = 3'h1;
    localparam logic [2:0] WDAY_MAX = 3'h7;
    localparam logic [4:0] DATE_MIN = 5'h01;
    localparam logic [3:0] MONTH_MIN = 4'h1;
    localparam logic [3:0] MONTH_MAX = 4'hc;
    localparam logic [7:0] YEAR_MAX = 8'h63;

    //=================================================================
    // timing: one calendar second in core clock cycles
    localparam int TICK_PERIOD_MS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SECOND_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    //=================================================================
    // calendar snapshot carried as one word
    typedef struct packed {
        logic [7:0] year;
        logic [3:0] month;
        logic [4:0] date;
        logic [2:0] weekday;
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } ccr_time_s;

    // last date of a month; year low bits zero marks a leap year
    function automatic logic [4:0] ccr_days_in_month(input logic [3:0] month,
                                                     input logic [7:0] year);
        logic [4:0] days;
        days = 5'h1f;
        case (month)
            4'h4, 4'h6, 4'h9, 4'hb: days = 5'h1e;
            4'h2: days = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c; // [R8]
            default: days = 5'h1f;
        endcase
        return days;
    endfunction : ccr_days_in_month

endpackage : ccr_pkg

// ===== src/ccr_tick.sv
// sub-second divider that emits one pulse per calendar second
`timescale 1ns/1ps
module ccr_tick #(
    parameter int CYCLES = ccr_pkg::SECOND_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic restart,
    output logic tick
);
    import ccr_pkg::*;

    //=================================================================
    // counter
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg; // position inside the current second
    logic [CW-1:0] count_next;
    logic tick_reg; // one-cycle second pulse
    wire at_last = (count_reg == LAST);

    // restart pulls the phase back to zero and drops a pending pulse
    assign count_next = (restart || at_last) ? '0 : count_reg + 1'b1; // [R1]

    // counter and pulse register
    always_ff @(posedge clock) begin
        if (reset) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= at_last && !restart;
        end
    end

    assign tick = tick_reg;

    //=================================================================
    // checks
    AST_RESTART_ZERO: assert property (@(posedge clock) disable iff (reset) // [R1]
        restart |=> (count_reg == '0) && !tick_reg)
        else $error("restart did not clear the sub-second counter");

endmodule : ccr_tick

// ===== src/ccr_wguard.sv
// write-enable guard: one enabling write arms exactly one time write
`timescale 1ns/1ps
module ccr_wguard (
    input wire logic clock,
    input wire logic reset,
    input wire logic arm,
    input wire logic consume,
    output logic armed
);
    import ccr_pkg::*;

    logic armed_reg; // set by the enable location, cleared by use
    logic armed_next;

    // a time write spends the permission whether or not it was armed
    assign armed_next = arm ? 1'b1 : (consume ? 1'b0 : armed_reg); // [R3] [R16]

    // permission flag
    always_ff @(posedge clock) begin
        if (reset) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end

    assign armed = armed_reg;

    AST_ARM_ONCE: assert property (@(posedge clock) disable iff (reset) // [R16]
        consume && !arm |=> !armed_reg)
        else $error("guard stayed armed after a time write");

endmodule : ccr_wguard

// ===== src/ccr_top.sv
// calendar clock registers: bus slave, calendar counter and rate trims
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ccr_top #(
    parameter int SECOND_CYCLES = ccr_pkg::SECOND_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [ccr_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [ccr_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [ccr_pkg::DATA_W-1:0] bus_rdata,
    output ccr_pkg::ccr_time_s time_now,
    output logic [6:0] analog_trim,
    output logic [1:0] fine_trim,
    output logic [16:0] coarse_trim,
    output logic second_tick
);
    import ccr_pkg::*;

    //=================================================================
    // address decode
    wire hit_restart = (bus_addr == OFS_RESTART);
    wire hit_analog = (bus_addr == OFS_ANALOG);
    wire hit_sec = (bus_addr == OFS_SEC);
    wire hit_min = (bus_addr == OFS_MIN);
    wire hit_hour = (bus_addr == OFS_HOUR);
    wire hit_wday = (bus_addr == OFS_WDAY);
    wire hit_date = (bus_addr == OFS_DATE);
    wire hit_month = (bus_addr == OFS_MONTH);
    wire hit_year = (bus_addr == OFS_YEAR);
    wire hit_c_hi = (bus_addr == OFS_COARSE_HI);
    wire hit_c_mid = (bus_addr == OFS_COARSE_MID);
    wire hit_trim_lo = (bus_addr == OFS_TRIM_LO);
    wire hit_wen = (bus_addr == OFS_WRITE_EN);

    // any of the seven calendar fields
    wire hit_time = hit_sec | hit_min | hit_hour | hit_wday | hit_date
                  | hit_month | hit_year; // [R2]

    //=================================================================
    // write guard
    logic armed; // a fresh enabling write is pending
    wire time_write = bus_write && hit_time;
    wire time_accept = time_write && armed; // [R3]

    ccr_wguard ccr_wguard_inst (
        .clock(clock),
        .reset(reset),
        .arm(bus_write && hit_wen),
        .consume(time_write),
        .armed(armed)
    );

    //=================================================================
    // sub-second divider
    wire restart_pulse = bus_write && hit_restart && bus_wdata[RESTART_BIT]; // [R1]

    ccr_tick #(
        .CYCLES(SECOND_CYCLES)
    ) ccr_tick_inst (
        .clock(clock),
        .reset(reset),
        .restart(restart_pulse),
        .tick(second_tick)
    );

    //=================================================================
    // calendar state
    ccr_time_s time_reg; // running calendar, no reset term
    ccr_time_s adv; // calendar after this cycle's second
    ccr_time_s time_next; // after a software load

    // wrap tests use >= so a bad value loaded by software recovers
    wire [4:0] month_days = ccr_days_in_month(time_reg.month, time_reg.year);
    wire sec_wrap = (time_reg.seconds >= SEC_MAX); // [R4]
    wire min_wrap = (time_reg.minutes >= MIN_MAX); // [R4]
    wire hour_wrap = (time_reg.hours >= HOUR_MAX); // [R5]
    wire wday_wrap = (time_reg.weekday >= WDAY_MAX); // [R6]
    wire date_wrap = (time_reg.date >= month_days); // [R7] [R8]
    wire month_wrap = (time_reg.month >= MONTH_MAX); // [R7]
    wire year_wrap = (time_reg.year >= YEAR_MAX); // [R8]

    // carry chain, one stage per field, except weekday and date, which share the day stage
    wire c_min = second_tick && sec_wrap; // [R15]
    wire c_hour = c_min && min_wrap;
    wire c_day = c_hour && hour_wrap;
    wire c_month = c_day && date_wrap;
    wire c_year = c_month && month_wrap;

    // advanced calendar
    assign adv.seconds = !second_tick ? time_reg.seconds
                       : (sec_wrap ? 6'h00 : time_reg.seconds + 6'h01); // [R15]
    assign adv.minutes = !c_min ? time_reg.minutes
                       : (min_wrap ? 6'h00 : time_reg.minutes + 6'h01);
    assign adv.hours = !c_hour ? time_reg.hours
                     : (hour_wrap ? 5'h00 : time_reg.hours + 5'h01); // [R5]
    assign adv.weekday = !c_day ? time_reg.weekday
                       : (wday_wrap ? WDAY_MIN : time_reg.weekday + 3'h1); // [R6]
    assign adv.date = !c_day ? time_reg.date
                    : (date_wrap ? DATE_MIN : time_reg.date + 5'h01); // [R7]
    assign adv.month = !c_month ? time_reg.month
                     : (month_wrap ? MONTH_MIN : time_reg.month + 4'h1);
    assign adv.year = !c_year ? time_reg.year
                    : (year_wrap ? 8'h00 : time_reg.year + 8'h01); // [R8]

    // software load of one field wins over its own advance
    assign time_next.seconds = (time_accept && hit_sec) ? bus_wdata[5:0] : adv.seconds; // [R2]
    assign time_next.minutes = (time_accept && hit_min) ? bus_wdata[5:0] : adv.minutes;
    assign time_next.hours = (time_accept && hit_hour) ? bus_wdata[4:0] : adv.hours;
    assign time_next.weekday = (time_accept && hit_wday) ? bus_wdata[2:0] : adv.weekday;
    assign time_next.date = (time_accept && hit_date) ? bus_wdata[4:0] : adv.date;
    assign time_next.month = (time_accept && hit_month) ? bus_wdata[3:0] : adv.month;
    assign time_next.year = (time_accept && hit_year) ? bus_wdata[7:0] : adv.year;

    // calendar register: chip reset must not touch it, so it has none;
    // retention through battery modes is the supply domain's job
    always_ff @(posedge clock) begin
        time_reg <= time_next; // [R9] [R10]
    end

    assign time_now = time_reg;

    //=================================================================
    // trims and restart bit
    logic restart_reg; // last value written to the restart bit
    logic [6:0] analog_reg; // analog oscillator trim
    logic [1:0] fine_reg; // secondary digital trim
    logic [16:0] coarse_reg; // primary digital trim

    // fine and coarse share one byte so a single write covers both
    wire [16:0] coarse_wr_hi = {bus_wdata[2:0], coarse_reg[13:0]};
    wire [16:0] coarse_wr_mid = {coarse_reg[16:14], bus_wdata, coarse_reg[5:0]};
    wire [16:0] coarse_wr_lo = {coarse_reg[16:6], bus_wdata[7:COARSE_LO_LSB]}; // [R14]

    wire [16:0] coarse_next = !bus_write ? coarse_reg
                            : hit_c_hi ? coarse_wr_hi
                            : hit_c_mid ? coarse_wr_mid
                            : hit_trim_lo ? coarse_wr_lo
                            : coarse_reg;

    // trim registers; range of coarse trim is left to software
    always_ff @(posedge clock) begin
        if (reset) begin
            restart_reg <= RESTART_RST;
            analog_reg <= ANALOG_RST; // [R12]
            fine_reg <= FINE_RST; // [R11]
            coarse_reg <= COARSE_RST;
        end else begin
            if (bus_write && hit_restart) begin
                restart_reg <= bus_wdata[RESTART_BIT];
            end
            if (bus_write && hit_analog) begin
                analog_reg <= bus_wdata[6:0]; // [R12]
            end
            if (bus_write && hit_trim_lo) begin
                fine_reg <= bus_wdata[FINE_MSB:0]; // [R11] [R14]
            end
            coarse_reg <= coarse_next; // [R14]
        end
    end

    assign analog_trim = analog_reg;
    assign fine_trim = fine_reg;
    assign coarse_trim = coarse_reg;

    //=================================================================
    // read path: data stand one cycle after the strobe
    wire [7:0] rd_mux = hit_restart ? {7'h00, restart_reg}
                      : hit_analog ? {1'b0, analog_reg}
                      : hit_sec ? {2'h0, time_reg.seconds}
                      : hit_min ? {2'h0, time_reg.minutes}
                      : hit_hour ? {3'h0, time_reg.hours}
                      : hit_wday ? {5'h00, time_reg.weekday}
                      : hit_date ? {3'h0, time_reg.date}
                      : hit_month ? {4'h0, time_reg.month}
                      : hit_year ? time_reg.year
                      : hit_c_hi ? {5'h00, coarse_reg[16:14]}
                      : hit_c_mid ? coarse_reg[13:6]
                      : hit_trim_lo ? {coarse_reg[5:0], fine_reg}
                      : 8'h00; // unmapped and write-enable read as zero

    logic [7:0] rdata_reg; // registered read answer

    // read data register, zero when no read was made
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_read ? rd_mux : 8'h00;
        end
    end

    assign bus_rdata = rdata_reg;

    //=================================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    AST_LOAD_SECONDS: assert property ( // [R2]
        time_accept && hit_sec |=> time_reg.seconds == $past(bus_wdata[5:0]))
        else $error("armed seconds write not loaded");

    AST_UNARMED_IGNORED: assert property ( // [R3]
        time_write && !armed && !second_tick |=> $stable(time_reg))
        else $error("unarmed time write changed the calendar");

    AST_SEC_WRAP: assert property ( // [R4]
        second_tick && time_reg.seconds == 6'h3b && !time_write
        |=> time_reg.seconds == 6'h00 && time_reg.minutes != $past(time_reg.minutes))
        else $error("seconds did not wrap into minutes");

    AST_HOUR_WRAP: assert property ( // [R5]
        c_hour && time_reg.hours == 5'h17 && !time_write |=> time_reg.hours == 5'h00)
        else $error("hour 23 did not wrap to 00");

    AST_WDAY_WRAP: assert property ( // [R6]
        c_day && time_reg.weekday == 3'h7 && !time_write |=> time_reg.weekday == 3'h1)
        else $error("weekday 07 did not wrap to 01");

    AST_FEB_LEAP: assert property ( // [R8]
        c_day && time_reg.month == 4'h2 && time_reg.date == 5'h1c
        && time_reg.year[1:0] == 2'h0 && !time_write
        |=> time_reg.date == 5'h1d && time_reg.month == 4'h2)
        else $error("leap February skipped day 29");

    AST_YEAR_WRAP: assert property ( // [R15]
        c_year && time_reg.year == 8'h63 && !time_write
        |=> time_reg.year == 8'h00 && time_reg.month == 4'h1 && time_reg.date == 5'h01)
        else $error("new year did not roll the calendar");

    AST_TRIM_RESET: assert property ( // [R11] [R12]
        $fell(reset) |-> analog_reg == 7'h40 && fine_reg == 2'h0)
        else $error("trim registers lost their reset values");

    AST_READ_SEC: assert property ( // [R2]
        bus_read && hit_sec |=> bus_rdata == {2'h0, $past(time_reg.seconds)} ##1
        bus_rdata == 8'h00 || $past(bus_read))
        else $error("seconds read answered wrong or late");

    AST_COMBINED_TRIM: assert property ( // [R14]
        bus_write && hit_trim_lo
        |=> fine_reg == $past(bus_wdata[1:0]) && coarse_reg[5:0] == $past(bus_wdata[7:2]))
        else $error("shared trim byte not split into both fields");

endmodule : ccr_top

// ===== tb/test_calendar_clock_registers.sv
// self-checking testbench of the calendar clock register block
`timescale 1ns/1ps
module test_calendar_clock_registers;
    import ccr_pkg::*;

    //=================================================================
    // settings and stimulus signals
    localparam int SEC_CYC = 64; // short second so a whole calendar load fits in one
    localparam int CYC_LIMIT = 20000; // run ceiling in clock cycles
    typedef struct packed {
        logic [1:0] what; // 0 read data, 1 calendar, 2 trims
        logic [41:0] val;
    } ccr_note_s;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    ccr_time_s time_now;
    logic [6:0] analog_trim;
    logic [1:0] fine_trim;
    logic [16:0] coarse_trim;
    logic second_tick;
    logic rd_d = 1'b0; // a read was taken at the last edge
    logic look = 1'b0; // bench asks the monitor to compare a port note
    ccr_note_s note_q[$]; // expected results, oldest first
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 43907;
    int n;
    logic [31:0] rnd;
    ccr_time_s g;
    ccr_time_s start_tab [7] = '{
        '{8'h63, 4'hc, 5'h1f, 3'h7, 5'h17, 6'h3b, 6'h3b}, // end of century
        '{8'h04, 4'h2, 5'h1c, 3'h3, 5'h17, 6'h3b, 6'h3b}, // leap february
        '{8'h03, 4'h2, 5'h1c, 3'h3, 5'h17, 6'h3b, 6'h3b}, // common february
        '{8'h00, 4'h2, 5'h1d, 3'h2, 5'h17, 6'h3b, 6'h3b}, // year zero is leap
        '{8'h15, 4'h4, 5'h1e, 3'h5, 5'h17, 6'h3b, 6'h3b}, // thirty-day month
        '{8'h15, 4'h6, 5'h0f, 3'h4, 5'h0a, 6'h3b, 6'h3b}, // minute into hour
        '{8'h15, 4'h6, 5'h0f, 3'h4, 5'h0a, 6'h14, 6'h3a}}; // no carry
    ccr_time_s exp_tab [7] = '{
        '{8'h00, 4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h00},
        '{8'h04, 4'h2, 5'h1d, 3'h4, 5'h00, 6'h00, 6'h00},
        '{8'h03, 4'h3, 5'h01, 3'h4, 5'h00, 6'h00, 6'h00},
        '{8'h00, 4'h3, 5'h01, 3'h3, 5'h00, 6'h00, 6'h00},
        '{8'h15, 4'h5, 5'h01, 3'h6, 5'h00, 6'h00, 6'h00},
        '{8'h15, 4'h6, 5'h0f, 3'h4, 5'h0b, 6'h00, 6'h00},
        '{8'h15, 4'h6, 5'h0f, 3'h4, 5'h0a, 6'h14, 6'h3b}};

    //=================================================================
    // design under test
    ccr_top #(.SECOND_CYCLES(SEC_CYC)) ccr_top_inst (
        .clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .time_now(time_now), .analog_trim(analog_trim), .fine_trim(fine_trim),
        .coarse_trim(coarse_trim), .second_tick(second_tick));

    // free-running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    //=================================================================
    // checking and closing
    task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // read data stands only in the cycle after the strobe, so flag that cycle
    always @(posedge clock) begin
        rd_d <= bus_read;
        cyc++;
        if (cyc == CYC_LIMIT) begin
            fail_count++; // hang: count it and close
            report_and_stop();
        end
    end

    // monitor: take the oldest note whenever a result is due
    always @(negedge clock) begin
        ccr_note_s nt;
        if (rd_d || look) begin
            if (note_q.size() == 0) begin
                cmp(42'h0, 42'h3ffffffffff); // result with no note counts as a mismatch
            end else begin
                nt = note_q.pop_front();
                if (nt.what == 2'h0) begin
                    cmp({34'h0, bus_rdata}, nt.val);
                end else if (nt.what == 2'h1) begin
                    cmp(42'(time_now), nt.val);
                end else begin
                    cmp({16'h0, coarse_trim, fine_trim, analog_trim}, nt.val);
                end
            end
        end
    end

    //=================================================================
    // bus and wait tasks; strobes change only by nba right after an edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        note_q.push_back('{2'h0, {34'h0, e}});
        @(posedge clock);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
    endtask : rd

    task automatic expect_port(input logic [1:0] w, input logic [41:0] v);
        note_q.push_back('{w, v});
        @(posedge clock);
        look <= 1'b1;
        @(posedge clock);
        look <= 1'b0;
    endtask : expect_port

    // every field needs its own guard write before it
    task automatic set_time(input ccr_time_s t);
        logic [7:0] f [7];
        f = '{{2'h0, t.seconds}, {2'h0, t.minutes}, {3'h0, t.hours}, {5'h0, t.weekday},
              {3'h0, t.date}, {4'h0, t.month}, t.year};
        for (int i = 0; i < 7; i++) begin
            wr(OFS_WRITE_EN, 8'h00);
            wr(OFS_SEC + 16'(i), f[i]);
        end
    endtask : set_time

    // counts falling edges until the tick shows; bounded so a dead divider ends
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (second_tick !== 1'b1 && k < 4 * SEC_CYC);
    endtask : wait_tick

    //=================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        // reset values of trims and control registers
        expect_port(2'h2, {16'h0, COARSE_RST, 2'h0, 7'h40});
        rd(OFS_ANALOG, 8'h40);
        rd(OFS_TRIM_LO, 8'h00);
        rd(OFS_COARSE_HI, 8'h04);
        rd(OFS_RESTART, 8'h00);
        rd(16'h2012, 8'h00);
        rd(OFS_WRITE_EN, 8'h00);
        // random analog trim values, written then read back at once
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            wr(OFS_ANALOG, rnd[7:0]);
            rd(OFS_ANALOG, {1'b0, rnd[6:0]});
        end
        // coarse trim at its lowest allowed value, fine trim beside it
        wr(OFS_COARSE_HI, 8'h03);
        wr(OFS_COARSE_MID, 8'hfe);
        wr(OFS_TRIM_LO, 8'hfe);
        expect_port(2'h2, {16'h0, 17'h0ffbf, 2'h2, rnd[6:0]});
        rd(OFS_TRIM_LO, 8'hfe);
        rd(OFS_COARSE_MID, 8'hfe);
        rd(OFS_COARSE_HI, 8'h03);
        // tick period, then a restart in mid-second
        wait_tick(n);
        wait_tick(n);
        cmp(42'(n), 42'(SEC_CYC));
        repeat (20) @(posedge clock);
        wr(OFS_RESTART, 8'h01);
        wait_tick(n);
        // counting starts in the write cycle, so one falling edge more than a period
        cmp(42'(n), 42'(SEC_CYC + 1));
        rd(OFS_RESTART, 8'h01);
        // calendar carries: load just after a restart, then watch one tick
        for (int i = 0; i < 7; i++) begin
            wr(OFS_RESTART, 8'h01);
            set_time(start_tab[i]);
            wait_tick(n);
            expect_port(2'h1, 42'(exp_tab[i]));
        end
        // guard: one arm, one time write; unarmed writes are dropped
        g = start_tab[5];
        wr(OFS_RESTART, 8'h01);
        set_time(g);
        wr(OFS_WRITE_EN, 8'h00);
        wr(OFS_ANALOG, 8'h33);
        wr(OFS_SEC, 8'h05);
        wr(OFS_MIN, 8'h07);
        g.seconds = 6'h05;
        expect_port(2'h1, 42'(g));
        rd(OFS_SEC, 8'h05);
        rd(OFS_MIN, {2'h0, g.minutes});
        // chip reset in mid-run keeps the calendar but restores the trims
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        expect_port(2'h1, 42'(g));
        expect_port(2'h2, {16'h0, COARSE_RST, 2'h0, 7'h40});
        repeat (2) @(posedge clock);
        report_and_stop();
    end

endmodule : test_calendar_clock_registers
